// >>> rtl/pcbr_cfg_defs.vh
// Constants of the bridge's configuration forwarding and termination core.
// Assumes it is included by its bare name from the design file.
`ifndef PCBR_CFG_DEFS_VH
`define PCBR_CFG_DEFS_VH
// ============================================================
// Register offsets (register bus, byte addresses)
`define PCBR_OFS_BUSNUM   8'h18
`define PCBR_OFS_CTRL     8'h3C
`define PCBR_OFS_STATUS   8'h40
`define PCBR_OFS_EVDIS    8'h64
// ============================================================
// Field positions
`define PCBR_BIT_MAMODE   5
`define PCBR_BIT_SERREN   8
`define PCBR_BIT_EVDIS_MA 4
`define PCBR_BIT_PRI_RMA  0
`define PCBR_BIT_SEC_RMA  1
// ============================================================
// Address and command encodings
`define PCBR_TYPE1        2'h1
`define PCBR_DEV_ALL      5'h1F
`define PCBR_FUNC_ALL     3'h7
`define PCBR_REG_ZERO     6'h00
`define PCBR_CMD_SPECIAL  4'h1
`define PCBR_CMD_CFGRD    4'hA
`define PCBR_CMD_CFGWR    4'hB
// ============================================================
// Reset values
`define PCBR_RST_BUSNUM   24'h000000
`define PCBR_RST_CTRL     16'h0000
`define PCBR_RST_EVDIS    8'h00
// ============================================================
// Timing: devsel wait in clocks after frame asserted
`define PCBR_DEVSEL_WAIT  3'h5
`endif

// >>> rtl/pcbr_cfg_forward.v
// Configuration forwarding decode, special-cycle conversion and
// master-side termination tracking of a two-port PCI bridge core.
// Assumes a bus sequencer presents address phases and reports target
// bus outcomes as one-cycle pulses on ref_clk; all inputs except sys_rst are synchronous.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "pcbr_cfg_defs.vh"

module pcbr_cfg_forward (
  input  wire        ref_clk,        // 250 MHz clock
  input  wire        sys_rst,        // Asynchronous reset, high
  // Register bus
  input  wire [7:0]  regAddr,        // Byte address
  input  wire [31:0] regWdata,       // Write data
  input  wire        regWr,          // Write strobe
  input  wire        regRd,          // Read strobe
  output reg  [31:0] regRdata,       // Read data, cycle after strobe
  // Address phase from the initiating bus
  input  wire        addrValid,      // Address phase pulse
  input  wire        addrFromSec,    // 1: initiated on secondary bus
  input  wire [31:0] addrAd,         // AD bus in address phase
  input  wire [3:0]  addrCmd,        // Command in address phase
  input  wire        burstReq,       // Initiator wants more phases
  // Target bus sequencing
  input  wire        tgtFrame,       // Our FRAME asserted on target bus
  input  wire        tgtDevsel,      // DEVSEL seen on target bus
  input  wire        tgtTrdy,        // TRDY seen on target bus
  input  wire        tgtStop,        // STOP seen on target bus
  input  wire        lastDword,      // Delivered last buffered dword
  input  wire        prefBoundary,   // Prefetch boundary reached
  input  wire        latTimerExp,    // Master latency timer expired
  input  wire        busGnt,         // Grant on target bus
  input  wire        isPosted,       // Current job is a posted write
  input  wire        isPrefetch,     // Current job is prefetching read
  input  wire        isMwi,          // Current job is write-invalidate
  // Decode results
  output reg         fwdDown,        // Forward type 1 downstream
  output reg         fwdUp,          // Forward type 1 upstream
  output reg         genSpecial,     // Generate special cycle
  output reg  [3:0]  outCmd,         // Command for target bus
  output reg  [31:0] outAd,          // Address for target bus
  output reg         tgtIgnore,      // Do not claim this address phase
  // Initiator-side answer
  output reg         respDevsel,     // Claim delayed txn on first try and repeats; after abort only for special cycles
  output reg         respTrdy,       // TRDY to initiator
  output reg         respStop,       // STOP to initiator
  // Target-bus master control
  output reg         mstFrame,       // Keep FRAME asserted
  output reg         mstIrdy,        // Keep IRDY asserted
  output reg         mstEnd,         // Transaction ended pulse
  output reg         mstAbort,       // Master abort pulse
  output reg         resumeWrite,    // Restart posted write remainder
  output reg         dropPosted,     // Discard posted data pulse
  output reg         termRetry,      // Retry seen pulse
  output reg         termDisc,       // Disconnect seen pulse
  output reg         termTgtAbort,   // Target abort seen pulse
  output reg         upstream_system_error_out // System error level
);

  // ============================================================
  // Configuration registers
  reg  [23:0] busNum_q;      // [7:0] primary, [15:8] sec, [23:16] sub
  reg  [15:0] ctrl_q;        // Bridge control and command bits
  reg  [7:0]  evDis_q;       // Event disable
  reg  [1:0]  rma_q;         // Received master abort, [0] pri [1] sec
  reg         dlyPend_q;     // Delayed transaction queued
  reg         dlyAborted_q;  // Its completion was a master abort
  reg         dlySpecial_q;  // It was a special-cycle conversion
  reg         dlyDone_q;     // Delayed job completed on target bus
  reg         dlySec_q;      // Delayed job came from secondary
  reg  [2:0]  waitCnt_q;     // Clocks since FRAME without DEVSEL
  reg         sawDevsel_q;   // DEVSEL seen earlier in transaction
  reg         dataMoved_q;   // A data phase has completed
  reg  [1:0]  abState_q;     // Master-abort sequence state
  reg         noRefetch_q;   // Prefetch cut by timer

  localparam [1:0] AB_IDLE = 2'h0;
  localparam [1:0] AB_FRM  = 2'h1;
  localparam [1:0] AB_IRDY = 2'h2;

  wire [7:0] priBus = busNum_q[7:0];
  wire [7:0] secBus = busNum_q[15:8];
  wire [7:0] subBus = busNum_q[23:16];

  // Type 1 special-cycle address pattern
  function isSpecialAd;
    input [31:0] ad;
    begin
      isSpecialAd = (ad[1:0] == `PCBR_TYPE1) &&
                    (ad[15:11] == `PCBR_DEV_ALL) &&
                    (ad[10:8] == `PCBR_FUNC_ALL) &&
                    (ad[7:2] == `PCBR_REG_ZERO);
    end
  endfunction

  // ============================================================
  // Address phase decode
  wire isCfg   = (addrCmd == `PCBR_CMD_CFGRD) || (addrCmd == `PCBR_CMD_CFGWR);
  wire isCfgWr = (addrCmd == `PCBR_CMD_CFGWR);
  wire isT1    = (addrAd[1:0] == `PCBR_TYPE1);
  wire [7:0] adBus = addrAd[23:16];
  wire inRangeEx = (adBus > secBus) && (adBus <= subBus);
  wire inRangeIn = (adBus >= secBus) && (adBus <= subBus);
  wire spcPat  = isSpecialAd(addrAd);
  wire spcDown = !addrFromSec && isCfgWr && spcPat && (adBus == secBus);
  wire spcUp   = addrFromSec && isCfgWr && spcPat && (adBus == priBus);
  wire dnHit   = !addrFromSec && isT1 && isCfg && inRangeEx;
  wire upHit   = addrFromSec && isT1 && isCfgWr && !inRangeIn &&
                 (addrAd[15:11] == `PCBR_DEV_ALL) &&
                 (addrAd[10:8] == `PCBR_FUNC_ALL);
  wire spcCmd  = (addrCmd == `PCBR_CMD_SPECIAL);

  // Master-abort condition on target bus
  wire abortNow = tgtFrame && !tgtDevsel && !sawDevsel_q &&
                  (waitCnt_q == `PCBR_DEVSEL_WAIT);
  wire tgtAbortSeen = tgtStop && !tgtDevsel && !tgtTrdy && sawDevsel_q;

  // ============================================================
  // Register writes and status
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busNum_q <= `PCBR_RST_BUSNUM;
      ctrl_q   <= `PCBR_RST_CTRL;
      evDis_q  <= `PCBR_RST_EVDIS;
      rma_q    <= 2'h0;
    end else begin
      if (regWr && regAddr == `PCBR_OFS_BUSNUM) begin
        busNum_q <= regWdata[23:0];
      end
      if (regWr && regAddr == `PCBR_OFS_CTRL) begin
        ctrl_q <= regWdata[15:0];
      end
      if (regWr && regAddr == `PCBR_OFS_EVDIS) begin
        evDis_q <= regWdata[7:0];
      end
      // Write one clears; a new abort in the same cycle wins
      if (regWr && regAddr == `PCBR_OFS_STATUS) begin
        rma_q <= rma_q & ~regWdata[1:0];
      end
      if (abortNow && !dlySpecial_q) begin
        if (dlySec_q) begin
          rma_q[`PCBR_BIT_PRI_RMA] <= 1'b1;
        end else begin
          rma_q[`PCBR_BIT_SEC_RMA] <= 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Register reads, answer in the following cycle
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `PCBR_OFS_BUSNUM: regRdata <= {8'h00, busNum_q};
        `PCBR_OFS_CTRL:   regRdata <= {16'h0000, ctrl_q};
        `PCBR_OFS_STATUS: regRdata <= {30'h00000000, rma_q};
        `PCBR_OFS_EVDIS:  regRdata <= {24'h000000, evDis_q};
        default:          regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // ============================================================
  // Decode outputs, registered one cycle after the address phase
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwdDown    <= 1'b0;
      fwdUp      <= 1'b0;
      genSpecial <= 1'b0;
      outCmd     <= 4'h0;
      outAd      <= 32'h00000000;
      tgtIgnore  <= 1'b0;
    end else if (addrValid) begin
      fwdDown    <= dnHit && !spcDown;
      fwdUp      <= upHit && !spcUp;
      genSpecial <= spcDown || spcUp;
      outCmd     <= (spcDown || spcUp) ? `PCBR_CMD_SPECIAL
                                       : addrCmd;
      outAd      <= addrAd;
      tgtIgnore  <= spcCmd;
    end else begin
      fwdDown    <= 1'b0;
      fwdUp      <= 1'b0;
      genSpecial <= 1'b0;
      tgtIgnore  <= 1'b0;
    end
  end

  // ============================================================
  // Delayed transaction tracking and initiator answers
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dlyPend_q    <= 1'b0;
      dlyAborted_q <= 1'b0;
      dlySpecial_q <= 1'b0;
      dlyDone_q    <= 1'b0;
      dlySec_q     <= 1'b0;
      respDevsel   <= 1'b0;
      respTrdy     <= 1'b0;
      respStop     <= 1'b0;
    end else begin
      respDevsel <= 1'b0;
      respTrdy   <= 1'b0;
      respStop   <= 1'b0;
      if (addrValid && !spcCmd && (dnHit || upHit || spcDown || spcUp)) begin
        if (!dlyPend_q) begin
          // Queue as delayed; initiator is retried meanwhile
          dlyPend_q    <= 1'b1;
          dlySpecial_q <= spcDown || spcUp;
          dlySec_q     <= addrFromSec;
          respDevsel   <= 1'b1;
          respStop     <= 1'b1;
        end else if (dlyAborted_q && !dlySpecial_q) begin
          // Repeat after abort: stay silent and retire
          dlyPend_q    <= 1'b0;
          dlyAborted_q <= 1'b0;
        end else if (dlyDone_q) begin
          respDevsel   <= 1'b1;
          respTrdy     <= 1'b1;
          respStop     <= burstReq;
          dlyPend_q    <= 1'b0;
          dlyDone_q    <= 1'b0;
          dlyAborted_q <= 1'b0;
        end else begin
          respDevsel <= 1'b1;
          respStop   <= 1'b1;
        end
      end
      if (abortNow && dlyPend_q) begin
        dlyAborted_q <= 1'b1;
        dlyDone_q    <= dlySpecial_q;
      end else if (dlyPend_q && tgtTrdy && tgtDevsel) begin
        dlyDone_q <= 1'b1;
      end
    end
  end

  // ============================================================
  // Target-bus master termination
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt_q   <= 3'h0;
      sawDevsel_q <= 1'b0;
      dataMoved_q <= 1'b0;
      abState_q   <= AB_IDLE;
      noRefetch_q <= 1'b0;
      mstFrame    <= 1'b0;
      mstIrdy     <= 1'b0;
      mstEnd      <= 1'b0;
      mstAbort    <= 1'b0;
      resumeWrite <= 1'b0;
      dropPosted  <= 1'b0;
      termRetry   <= 1'b0;
      termDisc    <= 1'b0;
      termTgtAbort <= 1'b0;
      upstream_system_error_out <= 1'b0;
    end else begin
      mstEnd       <= 1'b0;
      mstAbort     <= 1'b0;
      resumeWrite  <= 1'b0;
      dropPosted   <= 1'b0;
      termRetry    <= 1'b0;
      termDisc     <= 1'b0;
      termTgtAbort <= 1'b0;
      // Devsel wait counter
      if (tgtFrame && !tgtDevsel && !sawDevsel_q &&
          waitCnt_q != `PCBR_DEVSEL_WAIT) begin
        waitCnt_q <= waitCnt_q + 3'h1;
      end else if (!tgtFrame && abState_q == AB_IDLE) begin
        waitCnt_q <= 3'h0;
      end
      if (tgtDevsel) begin
        sawDevsel_q <= 1'b1;
      end
      if (tgtTrdy && tgtDevsel) begin
        dataMoved_q <= 1'b1;
      end
      case (abState_q)
        AB_IDLE: begin
          mstFrame <= tgtFrame;
          mstIrdy  <= tgtFrame;
          if (abortNow) begin
            mstAbort <= 1'b1;
            dropPosted <= isPosted;
            upstream_system_error_out <= isPosted &&
              ctrl_q[`PCBR_BIT_MAMODE] && ctrl_q[`PCBR_BIT_SERREN] &&
              !evDis_q[`PCBR_BIT_EVDIS_MA];
            mstFrame  <= 1'b0;
            mstIrdy   <= 1'b1;
            abState_q <= AB_IRDY;
          end else if (tgtFrame && tgtStop && tgtDevsel) begin
            termRetry <= !tgtTrdy && !dataMoved_q;
            termDisc  <= tgtTrdy || dataMoved_q;
            resumeWrite <= isPosted && !lastDword;
            abState_q <= AB_FRM;
          end else if (tgtFrame && tgtAbortSeen) begin
            termTgtAbort <= 1'b1;
            abState_q <= AB_FRM;
          end else if (tgtFrame && ((tgtTrdy && !isPosted && !isPrefetch) ||
                       (isPrefetch && prefBoundary) ||
                       (isPosted && lastDword))) begin
            abState_q <= AB_FRM;
          end else if (tgtFrame && !isMwi && latTimerExp && !busGnt) begin
            resumeWrite <= isPosted && !lastDword;
            noRefetch_q <= isPrefetch;
            abState_q <= AB_FRM;
          end
        end
        AB_FRM: begin
          // Frame drops first; irdy held for last phase
          mstFrame  <= 1'b0;
          mstIrdy   <= 1'b1;
          abState_q <= AB_IRDY;
        end
        AB_IRDY: begin
          mstIrdy     <= 1'b0;
          mstFrame    <= 1'b0;
          mstEnd      <= 1'b1;
          sawDevsel_q <= 1'b0;
          dataMoved_q <= 1'b0;
          waitCnt_q   <= 3'h0;
          abState_q   <= AB_IDLE;
        end
        default: abState_q <= AB_IDLE;
      endcase
      if (addrValid && !isPrefetch) begin
        noRefetch_q <= 1'b0;
      end
    end
  end

endmodule // pcbr_cfg_forward

// >>> verification/pcbr_cfg_forward_assertions.sv
// Port-level checker for the configuration forwarding core.
// Assumes one clock domain and a bind onto every design instance.
`timescale 1ns/10ps
module pcbr_cfg_forward_chk (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        addrValid,
  input wire logic [31:0] addrAd,
  input wire logic [3:0]  addrCmd,
  input wire logic        fwdDown,
  input wire logic        fwdUp,
  input wire logic        genSpecial,
  input wire logic        tgtIgnore,
  input wire logic [3:0]  outCmd,
  input wire logic [31:0] outAd,
  input wire logic        respDevsel,
  input wire logic        respTrdy,
  input wire logic        respStop,
  input wire logic        tgtFrame,
  input wire logic        tgtDevsel,
  input wire logic        mstFrame,
  input wire logic        mstIrdy,
  input wire logic        mstEnd,
  input wire logic        mstAbort,
  input wire logic        isPosted,
  input wire logic        dropPosted,
  input wire logic        upstream_system_error_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] frameCnt_q; // Clocks of FRAME without DEVSEL
  // ==================================================================
  // Unclaimed frame counter, saturating at seven
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      frameCnt_q <= 3'h0;
    else if (!tgtFrame || tgtDevsel)
      frameCnt_q <= 3'h0;
    else if (frameCnt_q != 3'h7)
      frameCnt_q <= frameCnt_q + 3'h1;
  end
  // ==================================================================
  // Assertions
  spec_cmd_a: assert property (genSpecial |->
    outCmd == 4'h1 && outAd == $past(addrAd)) else $error("special cmd");
  fwd_keep_a: assert property ((fwdDown || fwdUp) |->
    outCmd == $past(addrCmd) && outAd == $past(addrAd)
    && $past(addrAd[1:0]) == 2'h1) else $error("forward altered");
  up_fields_a: assert property (fwdUp |-> $past(addrValid) &&
    $past(addrAd[15:8]) == 8'hFF && $past(addrCmd) == 4'hB)
    else $error("upstream fields");
  spec_fields_a: assert property (genSpecial |->
    $past(addrAd[15:0]) == 16'hFF01 && $past(addrCmd) == 4'hB)
    else $error("special fields");
  spec_ignore_a: assert property (addrValid && addrCmd == 4'h1 |=>
    tgtIgnore && !fwdDown && !fwdUp && !genSpecial)
    else $error("special not ignored");
  resp_claim_a: assert property ((respTrdy || respStop) |->
    respDevsel) else $error("answer without claim");
  abort_early_a: assert property (mstAbort |-> frameCnt_q >= 3'h5)
    else $error("abort too early");
  abort_seq_a: assert property (mstAbort |-> ##[0:1]
    (!mstFrame && mstIrdy) ##1 (!mstIrdy && mstEnd))
    else $error("abort sequence");
  drop_posted_a: assert property (dropPosted |-> $past(isPosted))
    else $error("drop outside posted");
  serr_cause_a: assert property ($rose(upstream_system_error_out)
    |-> $past(isPosted)) else $error("system error cause");
  cover property (genSpecial);
  cover property (mstAbort);
  cover property (dropPosted);
endmodule // pcbr_cfg_forward_chk
bind pcbr_cfg_forward pcbr_cfg_forward_chk u_chk (.ref_clk, .sys_rst,
  .addrValid, .addrAd, .addrCmd, .fwdDown, .fwdUp, .genSpecial,
  .tgtIgnore, .outCmd, .outAd, .respDevsel, .respTrdy, .respStop,
  .tgtFrame, .tgtDevsel, .mstFrame, .mstIrdy, .mstEnd, .mstAbort,
  .isPosted, .dropPosted, .upstream_system_error_out);

// >>> verification/pcbr_tgt_model.sv
// Target-bus partner: a PCI target that claims late, retries or stays silent.
// Assumes tgtFrame stands for the initiator's FRAME on the target bus.
`timescale 1ns/10ps
module pcbr_tgt_model (
  input  wire logic       ref_clk,   // Bus clock
  input  wire logic       sys_rst,   // Async reset, high
  input  wire logic       tgtFrame,  // FRAME asserted
  input  wire logic       claim,     // 1 answers, 0 silent
  input  wire logic       retry,     // 1 answers with target retry
  input  wire logic [2:0] lat,       // Clocks before DEVSEL
  output reg              tgtDevsel, // DEVSEL asserted
  output reg              tgtTrdy,   // TRDY asserted
  output reg              tgtStop    // STOP asserted
);
  reg [2:0] waitCnt_q; // Clocks since FRAME
  // ==================================================================
  // Released lines read deasserted, as the pull-ups leave them
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst || !tgtFrame) begin
      waitCnt_q <= 3'h0;
      tgtDevsel <= 1'b0;
      tgtTrdy   <= 1'b0;
      tgtStop   <= 1'b0;
    end else if (waitCnt_q < lat) begin
      waitCnt_q <= waitCnt_q + 3'h1;
    end else if (claim) begin
      tgtDevsel <= 1'b1; // Completion, or retry with no data
      tgtTrdy   <= !retry;
      tgtStop   <= retry;
    end
  end
  // Never aborts, so DEVSEL-before-abort holds trivially
endmodule // pcbr_tgt_model

// >>> verification/tb_pci_bridge_cfg_forward_termination.sv
// Self-checking bench for the configuration forwarding core.
// Assumes the design, checker and target model are compiled first.
`timescale 1ns/10ps
`include "pcbr_cfg_defs.vh"
module tb_pci_bridge_cfg_forward_termination;
  reg ref_clk, sys_rst, regWr, regRd, addrValid, addrFromSec, burstReq;
  reg tgtFrame, lastDword, prefBoundary, latTimerExp, busGnt, isPosted;
  reg isPrefetch, isMwi, claim, seenAbort, seenDrop;
  reg retry, seenRetry, seenDisc;
  reg  [7:0]  regAddr;
  reg  [31:0] regWdata, addrAd;
  reg  [3:0]  addrCmd;
  wire [31:0] regRdata, outAd;
  wire [3:0]  outCmd;
  wire fwdDown, fwdUp, genSpecial, tgtIgnore, respDevsel, respTrdy;
  wire respStop, mstAbort, dropPosted, tgtDevsel, tgtTrdy, tgtStop;
  wire upstream_system_error_out;
  wire termRetry, termDisc;
  integer num_errors, n_compared, cyc, i;
  pcbr_cfg_forward dut (.ref_clk, .sys_rst, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .addrValid, .addrFromSec, .addrAd, .addrCmd,
    .burstReq, .tgtFrame, .tgtDevsel, .tgtTrdy, .tgtStop, .lastDword,
    .prefBoundary, .latTimerExp, .busGnt, .isPosted, .isPrefetch, .isMwi,
    .fwdDown, .fwdUp, .genSpecial, .outCmd, .outAd, .tgtIgnore,
    .respDevsel, .respTrdy, .respStop, .mstFrame(), .mstIrdy(), .mstEnd(),
    .mstAbort, .resumeWrite(), .dropPosted, .termRetry, .termDisc,
    .termTgtAbort(), .upstream_system_error_out);
  pcbr_tgt_model u_tgt (.ref_clk, .sys_rst, .tgtFrame, .claim, .retry,
    .lat(3'h2), .tgtDevsel, .tgtTrdy, .tgtStop);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  function [31:0] t1(input [7:0] b, input [4:0] d, input [2:0] f,
                     input [5:0] r);
    t1 = {8'h00, b, d, f, r, 2'h1};
  endfunction
  task conclude;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [35:0] seen, input [35:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rst;
    begin
      sys_rst <= 1'b1;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge ref_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdata, e);
    end
  endtask
  // Address phase; returns with the answer cycle settled
  task ap(input fs, input [31:0] ad, input [3:0] cmd);
    begin
      @(posedge ref_clk);
      addrValid   <= 1'b1;
      addrFromSec <= fs;
      addrAd      <= ad;
      addrCmd     <= cmd;
      @(posedge ref_clk);
      addrValid <= 1'b0;
      #1;
    end
  endtask
  task dec(input fs, input [31:0] ad, input [3:0] cmd, input [3:0] e);
    begin
      ap(fs, ad, cmd);
      chk({fwdDown, fwdUp, genSpecial, tgtIgnore}, e);
      if (e[1])
        chk({outCmd, outAd}, {`PCBR_CMD_SPECIAL, ad});
      if (e[3] | e[2])
        chk({outCmd, outAd}, {cmd, ad});
    end
  endtask
  // Frame on the target bus; drop it once the abort shows
  task run(input cl);
    begin
      seenAbort = 1'b0;
      seenDrop  = 1'b0;
      seenRetry = 1'b0;
      seenDisc  = 1'b0;
      @(posedge ref_clk);
      claim    <= cl;
      tgtFrame <= 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge ref_clk);
        #1;
        if (mstAbort === 1'b1) begin
          seenAbort = 1'b1;
          tgtFrame <= 1'b0;
        end
        if (dropPosted === 1'b1)
          seenDrop = 1'b1;
        if (termRetry === 1'b1)
          seenRetry = 1'b1;
        if (termDisc === 1'b1)
          seenDisc = 1'b1;
      end
      tgtFrame <= 1'b0;
    end
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  initial begin
    {num_errors, n_compared, cyc} = 0;
    {sys_rst, regWr, regRd, addrValid, addrFromSec, burstReq} = 6'h20;
    {tgtFrame, lastDword, prefBoundary, latTimerExp, busGnt} = 5'h00;
    {isPosted, isPrefetch, isMwi, claim, retry} = 5'h00;
    {regAddr, regWdata, addrAd, addrCmd} = 76'h0;
    rst;
    rd(`PCBR_OFS_BUSNUM, 32'h0);
    rd(`PCBR_OFS_CTRL, 32'h0);
    rd(`PCBR_OFS_STATUS, 32'h0);
    rd(`PCBR_OFS_EVDIS, 32'h0);
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h44, 32'h0);
    $display("test 1 done");
    wr(`PCBR_OFS_BUSNUM, 32'h0005_0201);
    rd(`PCBR_OFS_BUSNUM, 32'h0005_0201);
    dec(0, t1(8'h03, 5'h00, 3'h0, 6'h04), `PCBR_CMD_CFGRD, 4'h8);
    dec(0, t1(8'h05, 5'h02, 3'h1, 6'h04), `PCBR_CMD_CFGWR, 4'h8);
    dec(0, t1(8'h06, 5'h00, 3'h0, 6'h04), `PCBR_CMD_CFGRD, 4'h0);
    dec(0, 32'h0003_0004, `PCBR_CMD_CFGRD, 4'h0);
    dec(1, t1(8'h09, 5'h1F, 3'h7, 6'h01), `PCBR_CMD_CFGWR, 4'h4);
    dec(1, t1(8'h09, 5'h1F, 3'h7, 6'h01), `PCBR_CMD_CFGRD, 4'h0);
    dec(1, t1(8'h02, 5'h1F, 3'h7, 6'h01), `PCBR_CMD_CFGWR, 4'h0);
    dec(1, t1(8'h09, 5'h1E, 3'h7, 6'h01), `PCBR_CMD_CFGWR, 4'h0);
    dec(0, t1(8'h02, 5'h1F, 3'h7, 6'h00), `PCBR_CMD_CFGWR, 4'h2);
    dec(1, t1(8'h01, 5'h1F, 3'h7, 6'h00), `PCBR_CMD_CFGWR, 4'h2);
    dec(0, t1(8'h02, 5'h1F, 3'h7, 6'h05), `PCBR_CMD_CFGWR, 4'h0);
    dec(0, t1(8'h02, 5'h1F, 3'h6, 6'h00), `PCBR_CMD_CFGWR, 4'h0);
    dec(0, t1(8'h03, 5'h00, 3'h0, 6'h00), `PCBR_CMD_SPECIAL, 4'h1);
    $display("test 2 done");
    rst;
    wr(`PCBR_OFS_BUSNUM, 32'h0005_0201);
    burstReq <= 1'b1;
    ap(0, t1(8'h02, 5'h1F, 3'h7, 6'h00), `PCBR_CMD_CFGWR);
    chk({respDevsel, respTrdy, respStop}, 3'b101);
    run(0);
    chk(seenAbort, 1'b1);
    rd(`PCBR_OFS_STATUS, 32'h0);
    ap(0, t1(8'h02, 5'h1F, 3'h7, 6'h00), `PCBR_CMD_CFGWR);
    chk({respDevsel, respTrdy, respStop}, 3'b111);
    $display("test 3 done");
    burstReq <= 1'b0;
    ap(0, t1(8'h03, 5'h00, 3'h0, 6'h04), `PCBR_CMD_CFGWR);
    chk({respDevsel, respTrdy, respStop}, 3'b101);
    run(0);
    rd(`PCBR_OFS_STATUS, 32'h2);
    ap(0, t1(8'h03, 5'h00, 3'h0, 6'h04), `PCBR_CMD_CFGWR);
    chk({respDevsel, respTrdy, respStop}, 3'b000);
    wr(`PCBR_OFS_STATUS, 32'h2);
    rd(`PCBR_OFS_STATUS, 32'h0);
    ap(1, t1(8'h09, 5'h1F, 3'h7, 6'h01), `PCBR_CMD_CFGWR);
    run(0);
    rd(`PCBR_OFS_STATUS, 32'h1);
    $display("test 4 done");
    rst;
    lastDword <= 1'b1;
    ap(0, t1(8'h04, 5'h00, 3'h0, 6'h08), `PCBR_CMD_CFGRD);
    run(1);
    chk({seenAbort, seenRetry, seenDisc}, 3'b000);
    rd(`PCBR_OFS_STATUS, 32'h0);
    retry <= 1'b1;
    run(1);
    chk({seenAbort, seenRetry, seenDisc}, 3'b010);
    retry <= 1'b0;
    $display("test 5 done");
    rst;
    lastDword <= 1'b0;
    busGnt   <= 1'b1;
    isPosted <= 1'b1;
    wr(`PCBR_OFS_CTRL, 32'h0000_0120);
    wr(`PCBR_OFS_EVDIS, 32'h0000_0010);
    rd(`PCBR_OFS_CTRL, 32'h0000_0120);
    run(0);
    chk({seenAbort, seenDrop, upstream_system_error_out}, 3'b110);
    wr(`PCBR_OFS_EVDIS, 32'h0);
    run(0);
    chk(upstream_system_error_out, 1'b1);
    $display("test 6 done");
    conclude;
  end
endmodule // tb_pci_bridge_cfg_forward_termination
